// ### hdl/qsc_pkg.sv
// Shared constants and types of the quad sample converter control block.
package qsc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 40_000_000;
  localparam int OSC_HZ     = 2_500_000;
  localparam int OSC_DIV    = CLK_HZ / OSC_HZ;
  localparam int CONV_EDGES = 78;

  // ****************************************
  // Sequence layout
  // ****************************************
  localparam int CH_COUNT   = 4;
  localparam int CH_EDGES   = 19;
  localparam int SEQ_EDGES  = CH_COUNT * CH_EDGES;
  localparam int RES_W      = 12;
  localparam int RES_MSB    = 11;
  localparam int PH_LAST    = 13;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // Pin synchroniser lanes
  // ****************************************
  localparam int SYNC_W    = 6;
  localparam int PIN_START = 0;
  localparam int PIN_CLK   = 1;
  localparam int PIN_OSC   = 2;
  localparam int PIN_CMP   = 3;
  localparam int PIN_CS    = 4;
  localparam int PIN_RD    = 5;

  typedef enum logic [1:0]
  {
    QSC_IDLE = 2'b01,
    QSC_CONV = 2'b10
  } qsc_state_t;

endpackage

// ### hdl/qsc_core.sv
// Result FIFO and sequencing/read-port logic of the quad sample converter.
`timescale 1ns/1ps

// ****************************************
// Result FIFO
// ****************************************
module qsc_fifo
#(
  parameter int W = 12,
  parameter int D = 8
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         flush,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed
  {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wr;
    logic [PW-1:0]       rd;
    logic [CW-1:0]       cnt;
  } qsc_fifo_t;

  qsc_fifo_t s_reg;
  qsc_fifo_t s_next;
  logic      push;
  logic      pop;

  assign in_ready  = (s_reg.cnt != CW'(D));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = s_reg.mem[s_reg.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    s_next = s_reg;
    if (flush)
    begin
      s_next.wr  = '0;
      s_next.rd  = '0;
      s_next.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        s_next.mem[s_reg.wr] = in_data;
        s_next.wr = (s_reg.wr == PW'(D - 1)) ? '0 : s_reg.wr + 1'b1;
      end
      if (pop)
        s_next.rd = (s_reg.rd == PW'(D - 1)) ? '0 : s_reg.rd + 1'b1;
      if (push && !pop)
        s_next.cnt = s_reg.cnt + 1'b1;
      else if (pop && !push)
        s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

endmodule // qsc_fifo

// ****************************************
// Converter control and read port
// ****************************************
module qsc_core
#(
  parameter int OSC_DIV    = qsc_pkg::OSC_DIV,
  parameter int CONV_EDGES = qsc_pkg::CONV_EDGES,
  parameter int DEPTH      = qsc_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Conversion control pins
  input  wire logic        sample_start,
  input  wire logic        conv_clk,
  input  wire logic        clk_pin_tied,
  output logic             conv_done_n,
  // Analog front end
  output logic             hold_all,
  output logic [1:0]       mux_sel,
  output logic [11:0]      dac_code,
  input  wire logic        cmp_high,
  // Host read port
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  output logic [11:0]      result_bus,
  output logic             result_oe
);
  localparam int SW = qsc_pkg::SYNC_W;

  typedef struct packed
  {
    logic [SW-1:0]       sy1;
    logic [SW-1:0]       sy2;
    logic [SW-1:0]       sy3;
    qsc_pkg::qsc_state_t fsm;
    logic [4:0]          div;
    logic [6:0]          ctr;
    logic [4:0]          ph;
    logic [1:0]          ch;
    logic [11:0]         trial;
    logic                hold;
    logic                done_n;
    logic [11:0]         dout;
    logic                oe;
  } qsc_state_s_t;

  qsc_state_s_t s_reg;
  qsc_state_s_t s_next;
  logic         tick;
  logic         start_rise;
  logic         rd_act;
  logic         rd_start;
  logic         seq_act;
  logic         store;
  logic         flush;
  logic         f_in_ready;
  logic         f_out_valid;
  logic [11:0]  f_out_data;
  logic [11:0]  word;

  // The pin levels pass two flops before use; the third flop feeds edges only.
  assign start_rise = s_reg.sy2[qsc_pkg::PIN_START]
                    & ~s_reg.sy3[qsc_pkg::PIN_START];
  // The divider runs free, so the first tick after a start lands anywhere
  // within one tick period. That spread gives the 77 to 78 tick span, and
  // it keeps a start edge from having to line up with the tick clock.
  assign tick = s_reg.sy2[qsc_pkg::PIN_OSC]
              ? (s_reg.div == 5'(OSC_DIV - 1))
              : (s_reg.sy2[qsc_pkg::PIN_CLK]
                 & ~s_reg.sy3[qsc_pkg::PIN_CLK]);
  assign rd_act = ~s_reg.sy2[qsc_pkg::PIN_CS]
                & ~s_reg.sy2[qsc_pkg::PIN_RD];
  assign rd_start = rd_act & ~(~s_reg.sy3[qsc_pkg::PIN_CS]
                               & ~s_reg.sy3[qsc_pkg::PIN_RD]);
  assign seq_act = (s_reg.ctr < 7'(qsc_pkg::SEQ_EDGES));
  assign store = (s_reg.fsm == qsc_pkg::QSC_CONV) & tick & seq_act
               & (s_reg.ph == 5'(qsc_pkg::PH_LAST));
  // Offset-binary trial code turned into two's complement by the MSB.
  assign word = {~s_reg.trial[qsc_pkg::RES_MSB],
                 s_reg.trial[qsc_pkg::RES_MSB-1:1],
                 s_reg.sy2[qsc_pkg::PIN_CMP]};
  assign flush = (s_reg.fsm == qsc_pkg::QSC_IDLE) & start_rise;

  // Results leave in the order stored, so the FIFO read index is the read
  // pointer. A start flushes it, and that rewinds the read order.
  qsc_fifo
  #(
    .W (qsc_pkg::RES_W),
    .D (DEPTH)
  )
  qsc_fifo_inst
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .flush     (flush),
    .in_valid  (store),
    .in_ready  (f_in_ready),
    .in_data   (word),
    .out_valid (f_out_valid),
    .out_ready (rd_start),
    .out_data  (f_out_data)
  );

  always_comb
  begin
    int b;
    b = 0;
    s_next = s_reg;
    s_next.sy1 = {rd_n, cs_n, cmp_high, clk_pin_tied, conv_clk,
                  sample_start};
    s_next.sy2 = s_reg.sy1;
    s_next.sy3 = s_reg.sy2;
    s_next.div = (s_reg.div == 5'(OSC_DIV - 1)) ? '0
               : s_reg.div + 5'h01;
    // A read start releases the flag. A completion in the same cycle
    // overrides it below, so the end of a sequence is never lost.
    if (rd_start)
      s_next.done_n = 1'b1;
    case (s_reg.fsm)
      qsc_pkg::QSC_IDLE:
      begin
        // Edges arriving mid-conversion are not looked at; only idle.
        if (start_rise)
        begin
          s_next.fsm    = qsc_pkg::QSC_CONV;
          s_next.hold   = 1'b1;
          s_next.done_n = 1'b1;
          s_next.ctr    = '0;
          s_next.ph     = '0;
          s_next.ch     = '0;
          s_next.trial  = '0;
        end
      end
      qsc_pkg::QSC_CONV:
      begin
        // A full FIFO stalls the sequence rather than losing a word.
        if (tick && !(store && !f_in_ready))
        begin
          s_next.ctr = s_reg.ctr + 7'h01;
          if (seq_act)
          begin
            // Phase one tries the MSB. Phases two to twelve each keep or drop the
            // bit tried one tick earlier and try the next one down; phase 13 settles bit 0.
            b = qsc_pkg::RES_MSB + 2 - int'(s_reg.ph);
            if (s_reg.ph == '0)
              s_next.trial = '0;
            else if (s_reg.ph < 5'(qsc_pkg::PH_LAST))
            begin
              if (s_reg.ph != 5'h01)
                s_next.trial[b] = s_reg.sy2[qsc_pkg::PIN_CMP];
              s_next.trial[b-1] = 1'b1;
            end
            else if (s_reg.ph == 5'(qsc_pkg::PH_LAST))
              s_next.trial[0] = s_reg.sy2[qsc_pkg::PIN_CMP];
            if (s_reg.ph == 5'(qsc_pkg::CH_EDGES - 1))
            begin
              s_next.ph = '0;
              s_next.ch = s_reg.ch + 2'h1;
            end
            else
              s_next.ph = s_reg.ph + 5'h01;
          end
          if (s_reg.ctr == 7'(CONV_EDGES - 1))
          begin
            s_next.fsm    = qsc_pkg::QSC_IDLE;
            s_next.done_n = 1'b0;
            s_next.hold   = 1'b0;
            s_next.ch     = '0;
          end
        end
      end
      default:
        s_next.fsm = qsc_pkg::QSC_IDLE;
    endcase
    // Only the shared port exists; order is the sole selector.
    if (rd_start && f_out_valid)
      s_next.dout = f_out_data;
    s_next.oe = rd_act;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_reg        <= '0;
      // Select and read rest high, so no read starts at release.
      s_reg.sy1    <= 6'h30;
      s_reg.sy2    <= 6'h30;
      s_reg.sy3    <= 6'h30;
      s_reg.fsm    <= qsc_pkg::QSC_IDLE;
      s_reg.done_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign conv_done_n = s_reg.done_n;
  assign hold_all    = s_reg.hold;
  assign mux_sel     = s_reg.ch;
  assign dac_code    = s_reg.trial;
  assign result_bus  = s_reg.dout;
  assign result_oe   = s_reg.oe;

endmodule // qsc_core

// ### tb/qsc_core_monitor.sv
// Port checker of the converter control block, bound to its top module.
`timescale 1ns/1ps
module qsc_core_monitor
#(
  parameter int OSC_DIV = 16
)
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Converter pins
  input wire logic        conv_done_n,
  input wire logic        hold_all,
  input wire logic [1:0]  mux_sel,
  // Host read port
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic [11:0] result_bus,
  input wire logic        result_oe
);
  // ****************************************
  // Checks
  // ****************************************
  int  span_reg;
  wire sel_rd = !cs_n && !rd_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Start jitter and pin synchronisers blur the span by about one tick.
  always_ff @(posedge sys_clk)
    if (sys_rst || $rose(hold_all))
      span_reg <= 0;
    else if (hold_all)
      span_reg <= span_reg + 1;
  a_start_holds: assert property
    ($rose(hold_all) |-> conv_done_n && mux_sel == 2'h0) else $error("start");
  a_hold_busy: assert property
    (hold_all |-> conv_done_n) else $error("done while holding");
  a_track_on_done: assert property
    ($fell(conv_done_n) |-> !hold_all && $past(hold_all)) else $error("track");
  a_mux_steps: assert property
    (hold_all && $past(hold_all) && mux_sel != $past(mux_sel)
     |-> mux_sel == $past(mux_sel) + 2'h1) else $error("channel order");
  a_span_count: assert property
    ($fell(conv_done_n) |-> span_reg inside {[77*OSC_DIV-2:78*OSC_DIV+4]})
    else $error("conversion span");
  a_oe_cause: assert property
    (result_oe |-> $past(sel_rd, 2) || $past(sel_rd, 3) || $past(sel_rd, 4))
    else $error("drive without read");
  a_oe_follows: assert property
    (sel_rd [*5] |-> result_oe) else $error("no drive in read");
  a_oe_drops: assert property
    (!sel_rd [*5] |-> !result_oe) else $error("bus not released");
  a_bus_stable: assert property
    (result_oe && $past(result_oe) |-> $stable(result_bus)) else $error("bus");
endmodule // qsc_core_monitor

bind qsc_core qsc_core_monitor #(.OSC_DIV(OSC_DIV)) qsc_core_monitor_inst
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .conv_done_n(conv_done_n),
  .hold_all(hold_all), .mux_sel(mux_sel), .cs_n(cs_n), .rd_n(rd_n),
  .result_bus(result_bus), .result_oe(result_oe)
);

// ### tb/qsc_afe_model.sv
// Analog front end stand-in: comparator against held channel levels.
`timescale 1ns/1ps
module qsc_afe_model
(
  // Converter side
  input  wire logic [1:0]  mux_sel,
  input  wire logic [11:0] dac_code,
  // Held levels, offset binary, channel 1 in the low bits
  input  wire logic [47:0] levels,
  output logic             cmp_high
);
  // The trial bit is kept while the held level is at or above the code.
  assign cmp_high = levels[mux_sel * 12 +: 12] >= dac_code;
endmodule // qsc_afe_model

// ### tb/test_quad_sample_convert_read_port.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
module test_quad_sample_convert_read_port;
  // ****************************************
  // Stimulus and checking
  // ****************************************
  logic        sys_clk = 0, sys_rst = 1, sample_start = 0, conv_clk = 0;
  logic        clk_pin_tied = 1, cs_n = 1, rd_n = 1, oe_q = 0;
  logic        cmp_high, conv_done_n, hold_all, result_oe;
  logic [1:0]  mux_sel;
  logic [11:0] dac_code, result_bus;
  logic [47:0] levels = 0;
  logic [11:0] note_q[$];
  int          errors = 0, check_count = 0, seed = 79248, n;
  int          reads[3] = '{5, 2, 4};
  initial forever #12.5 sys_clk = ~sys_clk;
  // External clock at the same tick rate as the internal divider.
  initial forever #200 conv_clk = ~conv_clk;
  qsc_core qsc_core_inst
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sample_start(sample_start),
    .conv_clk(conv_clk), .clk_pin_tied(clk_pin_tied),
    .conv_done_n(conv_done_n), .hold_all(hold_all), .mux_sel(mux_sel),
    .dac_code(dac_code), .cmp_high(cmp_high), .cs_n(cs_n), .rd_n(rd_n),
    .result_bus(result_bus), .result_oe(result_oe)
  );
  qsc_afe_model qsc_afe_model_inst
  (
    .mux_sel(mux_sel), .dac_code(dac_code), .levels(levels),
    .cmp_high(cmp_high)
  );
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic pulse_start();
    sample_start = 1;
    tick(3);
    sample_start = 0;
  endtask
  task automatic read_word(input logic [11:0] exp);
    note_q.push_back(exp);
    cs_n = 0;
    rd_n = 0;
    tick(6);
    cs_n = 1;
    rd_n = 1;
    tick(5);
  endtask
  always @(negedge sys_clk)
  begin
    if (result_oe === 1'b1 && oe_q === 1'b0)
      check(result_bus, note_q.pop_front());
    oe_q <= result_oe;
  end
  initial
  begin
    tick(12);
    sys_rst = 0;
    tick(4);
    check({11'h0, conv_done_n}, 12'h1);
    for (int r = 0; r < 3; r++)
    begin
      levels[31:0] = $random(seed);
      levels[47:32] = 16'($random(seed));
      clk_pin_tied = (r != 1);
      pulse_start();
      tick(300);
      pulse_start();
      n = 0;
      while (conv_done_n !== 1'b0 && n < 2000)
      begin
        tick(1);
        n++;
      end
      if (n == 2000)
      begin
        errors++;
        break;
      end
      // Reads past the fourth re-present the channel 4 word.
      for (int i = 0; i < reads[r]; i++)
        read_word(levels[(i > 3 ? 3 : i) * 12 +: 12] ^ 12'h800);
      check({11'h0, conv_done_n}, 12'h1);
    end
    tally_and_finish();
  end
  initial
  begin
    #1000000;
    errors++;
    tally_and_finish();
  end
endmodule // test_quad_sample_convert_read_port
